// ---- design/tcm_pkg.sv ----
// Shared constants and carrier types for the tightly coupled memory controller
package tcm_pkg;
    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int DCB_ADDR_W = 10;
    localparam int DS_ADDR_W = 22;
    localparam int IS_ADDR_W = 21;
    localparam int DS_DATA_W = 32;
    localparam int IS_DATA_W = 64;
    localparam int REG8_W = 8;
    localparam int REG32_W = 32;
    localparam int REGION_W = 24;
    // ------------------------------------------------------------
    // Register offsets relative to each controller's base
    // ------------------------------------------------------------
    localparam logic [1:0] OFF_CTRL = 2'h0;
    localparam logic [1:0] OFF_RANGE = 2'h1;
    localparam logic [1:0] OFF_INIT = 2'h2;
    localparam logic [1:0] OFF_FILL = 2'h3;
    // ------------------------------------------------------------
    // Control register fields and reset values
    // ------------------------------------------------------------
    localparam int CTRL_EN_BIT = 7;
    localparam int CTRL_MULTI_BIT = 6;
    localparam int CTRL_WAIT_LSB = 0;
    localparam int CTRL_WAIT_W = 3;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] RANGE_RST = 8'h00;
    localparam logic [31:0] INIT_RST = 32'h00000000;
    localparam logic [31:0] FILL_RST = 32'h00000000;
    // ------------------------------------------------------------
    // Access timing in cycles
    // ------------------------------------------------------------
    localparam int MULTI_MIN_CYC = 2;
    localparam int MULTI_MAX_CYC = 8;
    localparam int CNT_W = 3;

    typedef struct packed {
        logic req;
        logic wr;
        logic [DCB_ADDR_W-1:0] addr;
        logic [REG32_W-1:0] wdata;
    } dcb_req_t;

    typedef struct packed {
        logic ack;
        logic [REG32_W-1:0] rdata;
    } dcb_rsp_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b010,
        ST_DONE = 3'b100
    } acc_state_t;
endpackage

// ---- design/tcm_ctrl.sv ----
// Instruction-side and data-side tightly coupled memory controllers
`timescale 1ns/100ps
// Summary of operation
// - Each side selects single-cycle or multi-cycle access of two to eight cycles.
// - Instruction RAM path is 64 bits wide, data RAM path 32 bits.
// - Either side may be built in or left out independently.
// - Each side decodes its own device control bus window.
// - Device control bus base addresses are parameters, not fixed.
// - Each side claims an independent 16 MB region of the processor map.
// - Direct addresses reach 64K bytes data side, 128K bytes instruction side.
// - Data side has separate 32-bit read and write buses.
// - Data side writes single bytes with per-byte enables.
// - Data side drives a 22-bit RAM address.
// - Data side holds 8-bit control and range registers.
// - Data RAM written by initial load, processor stores or fabric port.
// - Instruction side reads two instructions per 64-bit fetch.
// - Instruction side has a 32-bit write-only port driven from the bus.
// - Instruction side drives a separate 21-bit RAM address.
// - Instruction side holds 8-bit control and range registers.
// - Instruction side holds 32-bit init and fill registers for loading RAM.
// - Instruction RAM written by bus registers plus write command.
// - Device control bus carries 10 bits of address, apart from memory map.
module tcm_ctrl #(
    parameter bit HAS_IS = 1'b1,
    parameter bit HAS_DS = 1'b1,
    parameter logic [9:0] IS_DCB_BASE = 10'h010,
    parameter logic [9:0] DS_DCB_BASE = 10'h020
) (
    input wire logic clk,
    input wire logic rst,
    input wire tcm_pkg::dcb_req_t dcb_req,
    output tcm_pkg::dcb_rsp_t dcb_rsp,
    input wire logic ds_req,
    input wire logic ds_we,
    input wire logic [3:0] ds_be,
    input wire logic [31:0] ds_cpu_addr,
    input wire logic [31:0] ds_cpu_wdata,
    output logic [31:0] ds_cpu_rdata,
    output logic ds_cpu_done,
    output logic [21:0] ds_ram_addr,
    output logic [31:0] ds_ram_wdata,
    output logic [3:0] ds_ram_we,
    output logic ds_ram_en,
    input wire logic [31:0] ds_ram_rdata,
    input wire logic is_req,
    input wire logic [31:0] is_cpu_addr,
    output logic [63:0] is_cpu_rdata,
    output logic is_cpu_done,
    output logic [20:0] is_ram_addr,
    output logic [31:0] is_ram_wdata,
    output logic [1:0] is_ram_we,
    output logic is_ram_en,
    input wire logic [63:0] is_ram_rdata
);
    // ------------------------------------------------------------
    // Device control bus decode
    // ------------------------------------------------------------
    logic [7:0] ds_ctrl_q, ds_range_q, is_ctrl_q, is_range_q;
    logic [31:0] is_init_q, is_fill_q;
    logic [1:0] dcb_off;
    logic is_hit, ds_hit, is_fill_wr;
    assign dcb_off = dcb_req.addr[1:0];
    // Window match on the upper bits of the 10-bit address
    assign is_hit = HAS_IS && (dcb_req.addr[9:2] == IS_DCB_BASE[9:2]);
    assign ds_hit = HAS_DS && (dcb_req.addr[9:2] == DS_DCB_BASE[9:2]);
    // Writing the fill register is the write command for the instruction RAM
    assign is_fill_wr = dcb_req.req && dcb_req.wr && is_hit && dcb_off == tcm_pkg::OFF_FILL;

    logic [31:0] dcb_rd;
    assign dcb_rd = is_hit ? (dcb_off == tcm_pkg::OFF_CTRL ? {24'h000000, is_ctrl_q} :
                              dcb_off == tcm_pkg::OFF_RANGE ? {24'h000000, is_range_q} :
                              dcb_off == tcm_pkg::OFF_INIT ? is_init_q : is_fill_q) :
                    ds_hit ? (dcb_off == tcm_pkg::OFF_CTRL ? {24'h000000, ds_ctrl_q} :
                              dcb_off == tcm_pkg::OFF_RANGE ? {24'h000000, ds_range_q} :
                              32'h00000000) : 32'h00000000;

    always_ff @(posedge clk) begin
        if (rst) begin
            ds_ctrl_q <= tcm_pkg::CTRL_RST;
            ds_range_q <= tcm_pkg::RANGE_RST;
            is_ctrl_q <= tcm_pkg::CTRL_RST;
            is_range_q <= tcm_pkg::RANGE_RST;
            is_init_q <= tcm_pkg::INIT_RST;
            is_fill_q <= tcm_pkg::FILL_RST;
            dcb_rsp <= '0;
        end else begin
            dcb_rsp.ack <= dcb_req.req;
            dcb_rsp.rdata <= (dcb_req.req && !dcb_req.wr) ? dcb_rd : 32'h00000000;
            if (dcb_req.req && dcb_req.wr && ds_hit) begin
                // Two 8-bit data-side registers
                if (dcb_off == tcm_pkg::OFF_CTRL) ds_ctrl_q <= dcb_req.wdata[7:0];
                if (dcb_off == tcm_pkg::OFF_RANGE) ds_range_q <= dcb_req.wdata[7:0];
            end
            if (dcb_req.req && dcb_req.wr && is_hit) begin
                // Instruction-side 8-bit and 32-bit registers
                if (dcb_off == tcm_pkg::OFF_CTRL) is_ctrl_q <= dcb_req.wdata[7:0];
                if (dcb_off == tcm_pkg::OFF_RANGE) is_range_q <= dcb_req.wdata[7:0];
                if (dcb_off == tcm_pkg::OFF_INIT) is_init_q <= dcb_req.wdata;
                if (dcb_off == tcm_pkg::OFF_FILL) is_fill_q <= dcb_req.wdata;
            end
        end
    end

    // ------------------------------------------------------------
    // Region decode
    // ------------------------------------------------------------
    logic ds_sel, is_sel;
    // Range register names the 16 MB region, top 8 address bits
    assign ds_sel = HAS_DS && ds_ctrl_q[tcm_pkg::CTRL_EN_BIT] && ds_req &&
                    ds_cpu_addr[31:tcm_pkg::REGION_W] == ds_range_q;
    assign is_sel = HAS_IS && is_ctrl_q[tcm_pkg::CTRL_EN_BIT] && is_req &&
                    is_cpu_addr[31:tcm_pkg::REGION_W] == is_range_q;

    // ------------------------------------------------------------
    // Per-side access sequencer, 0 = data, 1 = instruction
    // ------------------------------------------------------------
    logic [1:0] sel, done_d;
    logic [1:0] multi;
    logic [2:0] lim [2];
    tcm_pkg::acc_state_t st_q [2];
    logic [2:0] cnt_q [2];
    logic [1:0] done_q;
    assign sel = {is_sel, ds_sel};
    assign multi = {is_ctrl_q[tcm_pkg::CTRL_MULTI_BIT], ds_ctrl_q[tcm_pkg::CTRL_MULTI_BIT]};
    // Wait field W gives W+2 cycles; 7 is clamped to 6 so no access exceeds 8 cycles
    logic [2:0] ds_wait, is_wait;
    assign ds_wait = ds_ctrl_q[tcm_pkg::CTRL_WAIT_LSB +: tcm_pkg::CTRL_WAIT_W];
    assign is_wait = is_ctrl_q[tcm_pkg::CTRL_WAIT_LSB +: tcm_pkg::CTRL_WAIT_W];
    assign lim[0] = (ds_wait == 3'h7) ? 3'h6 : ds_wait;
    assign lim[1] = (is_wait == 3'h7) ? 3'h6 : is_wait;

    generate
        for (genvar s = 0; s < 2; s++) begin : g_side
            // Single-cycle finishes in the request cycle edge; multi waits 2 to 8
            assign done_d[s] = (st_q[s] == tcm_pkg::ST_IDLE && sel[s] && !multi[s]) ||
                               (st_q[s] == tcm_pkg::ST_WAIT && cnt_q[s] == lim[s]);
            always_ff @(posedge clk) begin
                if (rst) begin
                    st_q[s] <= tcm_pkg::ST_IDLE;
                    cnt_q[s] <= 3'h0;
                    done_q[s] <= 1'b0;
                end else begin
                    done_q[s] <= done_d[s];
                    unique case (st_q[s])
                        tcm_pkg::ST_IDLE: begin
                            cnt_q[s] <= 3'h0;
                            if (sel[s] && multi[s]) st_q[s] <= tcm_pkg::ST_WAIT;
                            else if (sel[s]) st_q[s] <= tcm_pkg::ST_DONE;
                        end
                        tcm_pkg::ST_WAIT: begin
                            cnt_q[s] <= cnt_q[s] + 3'h1;
                            if (cnt_q[s] == lim[s]) st_q[s] <= tcm_pkg::ST_DONE;
                        end
                        tcm_pkg::ST_DONE: st_q[s] <= tcm_pkg::ST_IDLE;
                        default: st_q[s] <= tcm_pkg::ST_IDLE;
                    endcase
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Data-side RAM port
    // ------------------------------------------------------------
    logic ds_start;
    assign ds_start = ds_sel && st_q[0] == tcm_pkg::ST_IDLE;
    always_ff @(posedge clk) begin
        if (rst) begin
            ds_ram_addr <= 22'h000000;
            ds_ram_wdata <= 32'h00000000;
            ds_ram_we <= 4'h0;
            ds_ram_en <= 1'b0;
            ds_cpu_rdata <= 32'h00000000;
            ds_cpu_done <= 1'b0;
        end else begin
            ds_ram_en <= ds_start;
            if (ds_start) begin
                // 22-bit word address; low 16 bits of bytes reach 64K
                ds_ram_addr <= ds_cpu_addr[23:2];
                ds_ram_wdata <= ds_cpu_wdata;
            end
            // Byte enables pulse once per store
            ds_ram_we <= (ds_start && ds_we) ? ds_be : 4'h0;
            ds_cpu_done <= done_q[0];
            // Read bus is a separate 32-bit path
            if (done_q[0]) ds_cpu_rdata <= ds_ram_rdata;
        end
    end

    // ------------------------------------------------------------
    // Instruction-side RAM port: fetch reads, bus-driven writes
    // ------------------------------------------------------------
    logic is_start;
    assign is_start = is_sel && st_q[1] == tcm_pkg::ST_IDLE;
    always_ff @(posedge clk) begin
        if (rst) begin
            is_ram_addr <= 21'h000000;
            is_ram_wdata <= 32'h00000000;
            is_ram_we <= 2'h0;
            is_ram_en <= 1'b0;
            is_cpu_rdata <= 64'h0000000000000000;
            is_cpu_done <= 1'b0;
        end else begin
            is_ram_en <= is_start || (HAS_IS && is_fill_wr);
            is_ram_we <= 2'h0;
            if (HAS_IS && is_fill_wr) begin
                // Init holds the byte address; fill data goes to one 32-bit half
                is_ram_addr <= is_init_q[23:3];
                is_ram_wdata <= dcb_req.wdata;
                is_ram_we <= is_init_q[2] ? 2'h1 : 2'h2;
            end else if (is_start) begin
                // 21-bit doubleword address; 128K bytes reachable directly
                is_ram_addr <= is_cpu_addr[23:3];
            end
            is_cpu_done <= done_q[1];
            // Two instructions per fetch on the 64-bit path
            if (done_q[1]) is_cpu_rdata <= is_ram_rdata;
        end
    end
endmodule

// ---- test/tcm_ctrl_properties.sv ----
// Port checks for the memory controller
`timescale 1ns/100ps
module tcm_ctrl_properties (
    input wire logic clk,
    input wire logic rst,
    input wire tcm_pkg::dcb_req_t dcb_req,
    input wire tcm_pkg::dcb_rsp_t dcb_rsp,
    input wire logic [3:0] ds_be,
    input wire logic [31:0] ds_cpu_addr,
    input wire logic ds_cpu_done,
    input wire logic [21:0] ds_ram_addr,
    input wire logic [3:0] ds_ram_we,
    input wire logic ds_ram_en,
    input wire logic [31:0] is_cpu_addr,
    input wire logic is_cpu_done,
    input wire logic [20:0] is_ram_addr,
    input wire logic [1:0] is_ram_we,
    input wire logic is_ram_en
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_ack_after_req: assert property (dcb_req.req |=> dcb_rsp.ack)
        else $error("ack late");
    a_ack_has_req: assert property (dcb_rsp.ack |-> $past(dcb_req.req))
        else $error("ack without request");
    a_ds_byte_we: assert property (ds_ram_we != 4'h0 |-> ds_ram_en && ds_ram_we == $past(ds_be))
        else $error("byte enables wrong");
    a_ds_addr_map: assert property (ds_ram_en |-> ds_ram_addr == 22'($past(ds_cpu_addr) >> 2))
        else $error("data address wrong");
    a_ds_done_bound: assert property (ds_ram_en |-> ##[1:8] ds_cpu_done)
        else $error("data access too long");
    a_is_fetch_addr: assert property (is_ram_en && is_ram_we == 2'h0
        |-> is_ram_addr == 21'($past(is_cpu_addr) >> 3))
        else $error("fetch address wrong");
    a_is_done_bound: assert property (is_ram_en && is_ram_we == 2'h0 |-> ##[1:8] is_cpu_done)
        else $error("fetch too long");
    a_is_half_write: assert property (is_ram_we != 2'h0 |-> is_ram_en && is_ram_we != 2'h3)
        else $error("fill writes both halves");
endmodule
bind tcm_ctrl tcm_ctrl_properties tcm_ctrl_properties_i (.clk, .rst, .dcb_req, .dcb_rsp,
    .ds_be, .ds_cpu_addr, .ds_cpu_done, .ds_ram_addr, .ds_ram_we, .ds_ram_en, .is_cpu_addr,
    .is_cpu_done, .is_ram_addr, .is_ram_we, .is_ram_en);

// ---- test/tcm_ram_model.sv ----
// Block RAMs behind both controller ports
`timescale 1ns/100ps
module tcm_ram_model (
    input wire logic clk,
    input wire logic [21:0] ds_ram_addr,
    input wire logic [31:0] ds_ram_wdata,
    input wire logic [3:0] ds_ram_we,
    input wire logic ds_ram_en,
    output logic [31:0] ds_ram_rdata,
    input wire logic [20:0] is_ram_addr,
    input wire logic [31:0] is_ram_wdata,
    input wire logic [1:0] is_ram_we,
    input wire logic is_ram_en,
    output logic [63:0] is_ram_rdata,
    input wire logic fab_en,
    input wire logic fab_we,
    input wire logic [7:0] fab_addr,
    input wire logic [31:0] fab_wdata
);
    logic [31:0] dmem [0:255];
    logic [63:0] imem [0:255];
    logic [31:0] ds_q;
    logic [63:0] is_q;
    initial begin
        for (int i = 0; i < 256; i++) begin
            dmem[i] = {24'h5A5A00, 8'(i)};
        end
    end
    // Only 256 words are kept, so high address bits alias
    always @(posedge clk) begin
        for (int b = 0; b < 4; b++) begin
            if (ds_ram_en && ds_ram_we[b]) dmem[ds_ram_addr[7:0]][8*b+:8] <= ds_ram_wdata[8*b+:8];
        end
        // Fabric side port of the data RAM, independent of the controller
        if (fab_en && fab_we) dmem[fab_addr] <= fab_wdata;
        if (is_ram_en && is_ram_we[1]) imem[is_ram_addr[7:0]][63:32] <= is_ram_wdata;
        if (is_ram_en && is_ram_we[0]) imem[is_ram_addr[7:0]][31:0] <= is_ram_wdata;
        if (ds_ram_en) ds_q <= dmem[ds_ram_addr[7:0]];
        if (is_ram_en) is_q <= imem[is_ram_addr[7:0]];
    end
    assign ds_ram_rdata = ds_ram_en ? dmem[ds_ram_addr[7:0]] : ds_q;
    assign is_ram_rdata = is_ram_en ? imem[is_ram_addr[7:0]] : is_q;
endmodule

// ---- test/test_tcm_ctrl.sv ----
// Self-checking bench for the memory controller
`timescale 1ns/100ps
module test_tcm_ctrl;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ds_req = 1'b0, ds_we = 1'b0, is_req = 1'b0, ds_cpu_done, is_cpu_done, ds_ram_en, is_ram_en;
    logic [3:0] ds_be = 4'h0, ds_ram_we;
    logic [31:0] ds_cpu_addr = 32'h0, ds_cpu_wdata = 32'h0, is_cpu_addr = 32'h0, ds_cpu_rdata;
    logic [31:0] ds_ram_wdata, ds_ram_rdata, is_ram_wdata, d, ex;
    logic [21:0] ds_ram_addr;
    logic [20:0] is_ram_addr;
    logic [1:0] is_ram_we;
    logic [63:0] is_cpu_rdata, is_ram_rdata;
    logic fab_en = 1'b0, fab_we = 1'b0;
    logic [7:0] fab_addr = 8'h00;
    logic [31:0] fab_wdata = 32'h0;
    logic [64:0] q[$], e;
    tcm_pkg::dcb_req_t dcb_req = '0;
    tcm_pkg::dcb_rsp_t dcb_rsp;
    int n_mismatch = 0, num_checks = 0, cyc = 0;
    integer seed = 32'h8a5a8419;
    always #2.5 clk = ~clk;
    tcm_ctrl tcm_ctrl_i (.clk, .rst, .dcb_req, .dcb_rsp, .ds_req, .ds_we, .ds_be, .ds_cpu_addr,
        .ds_cpu_wdata, .ds_cpu_rdata, .ds_cpu_done, .ds_ram_addr, .ds_ram_wdata, .ds_ram_we,
        .ds_ram_en, .ds_ram_rdata, .is_req, .is_cpu_addr, .is_cpu_rdata, .is_cpu_done,
        .is_ram_addr, .is_ram_wdata, .is_ram_we, .is_ram_en, .is_ram_rdata);
    tcm_ram_model tcm_ram_model_i (.clk, .ds_ram_addr, .ds_ram_wdata, .ds_ram_we, .ds_ram_en,
        .ds_ram_rdata, .is_ram_addr, .is_ram_wdata, .is_ram_we, .is_ram_en, .is_ram_rdata,
        .fab_en, .fab_we, .fab_addr, .fab_wdata);
    task chk(input logic [63:0] s, input logic [63:0] x);
        num_checks++;
        if (s !== x) begin
            n_mismatch++;
            $display("Error at %0t: saw %h expected %h", $time, s, x);
        end
    endtask
    task print_verdict;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // One bus cycle; the expected reply is queued, c says if it is compared
    task bus(input bit wr, input logic [9:0] a, input logic [31:0] w, input bit c, input logic [31:0] x);
        @(posedge clk);
        #1;
        dcb_req = '{1'b1, wr, a, w};
        q.push_back({c, 32'h0, x});
        @(posedge clk);
        #1;
        dcb_req.req = 1'b0;
    endtask
    // Request held until completion; n is the expected edge count, 20 means refused
    task acc(input bit is, input bit we, input logic [3:0] be, input logic [31:0] a,
        input logic [31:0] w, input bit c, input logic [63:0] x, input int n);
        int k;
        @(posedge clk);
        #1;
        if (n < 20) q.push_back({c, x});
        {ds_we, ds_be, ds_cpu_addr, ds_cpu_wdata, is_cpu_addr} = {we, be, a, w, a};
        {is_req, ds_req} = {is, !is};
        k = 0;
        do begin
            @(posedge clk);
            #1;
            k++;
        end while (ds_cpu_done !== 1'b1 && is_cpu_done !== 1'b1 && k < 20);
        {is_req, ds_req} = 2'b00;
        chk(64'(k), 64'(n));
    endtask
    always @(negedge clk) begin
        if (dcb_rsp.ack === 1'b1 || ds_cpu_done === 1'b1 || is_cpu_done === 1'b1) begin
            e = (q.size() != 0) ? q.pop_front() : {1'b1, 64'hBAD};
            if (e[64]) chk(dcb_rsp.ack ? 64'(dcb_rsp.rdata) : ds_cpu_done ? 64'(ds_cpu_rdata)
                : is_cpu_rdata, e[63:0]);
        end
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 4000) begin
            n_mismatch++;
            print_verdict();
        end
    end
    initial begin
        repeat (8) @(posedge clk);
        #1;
        rst = 1'b0;
        for (int i = 0; i < 4; i++) begin
            bus(0, 10'h010 + 10'(i), 0, 1, 0);
            bus(0, 10'h020 + 10'(i), 0, 1, 0);
        end
        bus(1, 10'h3FC, 32'hFFFFFFFF, 0, 0);
        bus(0, 10'h3FC, 0, 1, 0);
        bus(1, 10'h020, 32'hFFFFFF80, 0, 0);
        bus(0, 10'h020, 0, 1, 32'h80);
        $display("registers test done");
        ex = 32'h5A5A0004;
        acc(0, 0, 4'h0, 32'h10, 0, 1, 64'(ex), 2);
        for (int b = 0; b < 16; b++) begin
            d = $random(seed);
            acc(0, 1, 4'(b), 32'h10, d, 0, 0, 2);
            for (int k = 0; k < 4; k++) if (b[k]) ex[8*k+:8] = d[8*k+:8];
            acc(0, 0, 4'h0, 32'h10, 0, 1, 64'(ex), 2);
        end
        $display("byte write test done");
        d = $random(seed);
        @(posedge clk);
        #1;
        {fab_en, fab_we, fab_addr, fab_wdata} = {1'b1, 1'b1, 8'h06, d};
        @(posedge clk);
        #1;
        {fab_en, fab_we} = 2'b00;
        acc(0, 0, 4'h0, 32'h18, 0, 1, 64'(d), 2);
        $display("fabric port test done");
        for (int w = 0; w < 8; w++) begin
            bus(1, 10'h020, 32'hC0 | 32'(w), 0, 0);
            acc(0, 0, 4'h0, 32'h10, 0, 1, 64'(ex), ((w < 6) ? w : 6) + 3);
        end
        bus(1, 10'h021, 32'h05, 0, 0);
        acc(0, 0, 4'h0, 32'h10, 0, 0, 0, 20);
        acc(0, 0, 4'h0, 32'h0500FFFC, 0, 1, 64'h5A5A00FF, 9);
        $display("mode and range test done");
        d = $random(seed);
        ex = $random(seed);
        bus(1, 10'h012, 32'h8, 0, 0);
        bus(1, 10'h013, d, 0, 0);
        bus(1, 10'h012, 32'hC, 0, 0);
        bus(1, 10'h013, ex, 0, 0);
        bus(0, 10'h013, 0, 1, ex);
        bus(1, 10'h010, 32'h80, 0, 0);
        acc(1, 0, 4'h0, 32'h8, 0, 1, {d, ex}, 2);
        $display("fetch test done");
        print_verdict();
    end
endmodule
